// file: pec_top.v
// Two 32-bit performance event counters behind coprocessor register 25
`timescale 1ns/100ps
`include "pec_regs.vh"
module pec_top #(
	parameter SCOPE_SUP = 1,
	parameter NUM_LINES = 8
) (
	input wire CLK_SYS,
	input wire ARST_N,
	input wire CORE_CLK_EN,
	input wire CP_WR,
	input wire CP_RD,
	input wire [4:0] CP_REGNUM,
	input wire [2:0] CP_SEL,
	input wire [31:0] CP_WDATA,
	output reg [31:0] CP_RDATA,
	output reg CP_RACK,
	input wire ROOT_MODE,
	input wire USER_MODE,
	input wire EXC_LEVEL,
	input wire ERROR_LEVEL,
	input wire DEBUG_ACTIVE_FLAG,
	input wire GUEST_ACTIVE_FLAG,
	input wire [63:0] EV0_IN,
	input wire [7:0] EV0_VIRT_IN,
	input wire [63:0] EV1_IN,
	input wire [7:0] EV1_VIRT_IN,
	input wire CUSTOM_EVENT_IN0,
	input wire CUSTOM_EVENT_IN1,
	input wire [2:0] PERF_IRQ_LINE_NUM,
	output reg PERF_IRQ_OUT,
	output reg [NUM_LINES-1:0] CORE_IRQ_INPUTS
);
	wire [1:0] custom_sync;
	wire reg_hit;
	wire [63:0] ctl_view_w;
	wire [63:0] cnt_view_w;
	wire [1:0] irq_term_w;
	wire irq_nxt;
	reg [31:0] rd_mux;
	reg [NUM_LINES-1:0] line_nxt;
	integer i;

	// Custom event pins come from outside logic, so resample first
	pec_sync #(
		.W(2)
	) u_sync (
		.clk(CLK_SYS),
		.arst_n(ARST_N),
		.d({CUSTOM_EVENT_IN1, CUSTOM_EVENT_IN0}),
		.q(custom_sync)
	);

	assign reg_hit = (CP_REGNUM == `PEC_CP_REG);

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : g_cnt
			localparam [2:0] SEL_CTL = (g == 0) ? `PEC_SEL_CTL0 :
				`PEC_SEL_CTL1;
			localparam [2:0] SEL_CNT = (g == 0) ? `PEC_SEL_CNT0 :
				`PEC_SEL_CNT1;
			localparam [63:0] M_LO = (g == 0) ? `PEC_MODE0_LO :
				`PEC_MODE1_LO;
			localparam [7:0] M_HI = (g == 0) ? `PEC_MODE0_HI :
				`PEC_MODE1_HI;
			localparam [63:0] V_LO = (g == 0) ? `PEC_VALID0_LO :
				`PEC_VALID1_LO;
			localparam [7:0] V_HI = (g == 0) ? `PEC_VALID0_HI :
				`PEC_VALID1_HI;
			// Only the first pair points at a further pair
			localparam [0:0] PAIR_NEXT = (g == 0) ? 1'b1 : 1'b0;

			reg [31:0] cnt_r;
			reg [31:0] cnt_nxt;
			reg [5:0] evt_r;
			reg [3:0] virt_r;
			reg [1:0] scope_r;
			reg gate_r;
			reg gate_nxt;
			reg app_r;
			reg priv_r;
			reg exc_r;
			reg armed_r;
			wire wr_ctl;
			wire wr_cnt;
			wire inc;
			wire [1:0] scope_rd;
			wire [63:0] ev_lo;
			wire [7:0] ev_virt;

			assign wr_ctl = CP_WR && reg_hit && (CP_SEL == SEL_CTL);
			assign wr_cnt = CP_WR && reg_hit && (CP_SEL == SEL_CNT);
			assign ev_lo = (g == 0) ? EV0_IN : EV1_IN;
			assign ev_virt = (g == 0) ? EV0_VIRT_IN : EV1_VIRT_IN;

			pec_evsel #(
				.MODE_LO(M_LO),
				.MODE_HI(M_HI),
				.VALID_LO(V_LO),
				.VALID_HI(V_HI)
			) u_evsel (
				.event_sel(evt_r),
				.virt_event_sel(virt_r),
				.context_scope(scope_r),
				.count_in_app_level(app_r),
				.count_in_priv_level(priv_r),
				.count_in_exc_level(exc_r),
				.ev_lo(ev_lo),
				.ev_virt(ev_virt),
				.custom_ev(custom_sync[g]),
				.user_mode(USER_MODE),
				.exc_level(EXC_LEVEL),
				.error_level(ERROR_LEVEL),
				.debug_active_flag(DEBUG_ACTIVE_FLAG),
				.guest_active_flag(GUEST_ACTIVE_FLAG),
				.inc(inc)
			);

			// Control fields; scope only changes from root context
			always @(posedge CLK_SYS or negedge ARST_N)
			begin
				if (!ARST_N)
				begin
					evt_r <= 6'h00;
					virt_r <= 4'h0;
					scope_r <= 2'h0;
					gate_r <= 1'b0;
					app_r <= 1'b0;
					priv_r <= 1'b0;
					exc_r <= 1'b0;
					armed_r <= 1'b0;
				end
				else if (wr_ctl)
				begin
					evt_r <= CP_WDATA[`PEC_B_EVT_HI:`PEC_B_EVT_LO];
					virt_r <= CP_WDATA[`PEC_B_VIRT_HI:`PEC_B_VIRT_LO];
					if (ROOT_MODE && SCOPE_SUP != 0)
						scope_r <= CP_WDATA[`PEC_B_SCOPE_HI:
							`PEC_B_SCOPE_LO];
					gate_r <= CP_WDATA[`PEC_B_IRQ];
					app_r <= CP_WDATA[`PEC_B_APP];
					priv_r <= CP_WDATA[`PEC_B_PRIV];
					exc_r <= CP_WDATA[`PEC_B_EXC];
					armed_r <= 1'b1;
				end
			end

			// Write outranks a same-cycle increment
			always @*
			begin
				cnt_nxt = cnt_r;
				gate_nxt = gate_r;
				if (wr_ctl)
					gate_nxt = CP_WDATA[`PEC_B_IRQ];
				if (wr_cnt)
					cnt_nxt = CP_WDATA;
				else if (inc && armed_r && CORE_CLK_EN)
					cnt_nxt = cnt_r + 32'h00000001;
			end

			// Undefined at reset in the architecture; zero keeps sims clean
			always @(posedge CLK_SYS or negedge ARST_N)
			begin
				if (!ARST_N)
					cnt_r <= 32'h00000000;
				else
					cnt_r <= cnt_nxt;
			end

			assign scope_rd = (ROOT_MODE && SCOPE_SUP != 0) ? scope_r :
				2'h0;
			// Unlisted positions stay zero on read
			assign ctl_view_w[g*32 +: 32] = {PAIR_NEXT,
				6'h00, scope_rd, 8'h00, virt_r, evt_r, gate_r,
				app_r, 1'b0, priv_r, exc_r};
			assign cnt_view_w[g*32 +: 32] = cnt_r;
			assign irq_term_w[g] = cnt_nxt[`PEC_B_TOP] && gate_nxt;
		end
	endgenerate

	// Irq tracks next counter state so it flags with the count itself
	assign irq_nxt = |irq_term_w;

	always @*
	begin
		line_nxt = {NUM_LINES{1'b0}};
		for (i = 0; i < NUM_LINES; i = i + 1)
		begin
			if (PERF_IRQ_LINE_NUM == i[2:0])
				line_nxt[i] = irq_nxt;
		end
	end

	always @*
	begin
		case (CP_SEL)
		`PEC_SEL_CTL0: rd_mux = ctl_view_w[31:0];
		`PEC_SEL_CNT0: rd_mux = cnt_view_w[31:0];
		`PEC_SEL_CTL1: rd_mux = ctl_view_w[63:32];
		`PEC_SEL_CNT1: rd_mux = cnt_view_w[63:32];
		default: rd_mux = 32'h00000000;
		endcase
	end

	// Read data is held until the next read of register 25
	always @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			CP_RDATA <= 32'h00000000;
			CP_RACK <= 1'b0;
		end
		else
		begin
			CP_RACK <= CP_RD && reg_hit;
			if (CP_RD && reg_hit)
				CP_RDATA <= rd_mux;
		end
	end

	always @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			PERF_IRQ_OUT <= 1'b0;
			CORE_IRQ_INPUTS <= {NUM_LINES{1'b0}};
		end
		else
		begin
			PERF_IRQ_OUT <= irq_nxt;
			CORE_IRQ_INPUTS <= line_nxt;
		end
	end
endmodule

// file: pec_regs.vh
// Constants for the two-counter performance event unit
// Operation
// - Each counter is 32-bit, incremented per event
// - Counters independent, one selected event each
// - Bit 31 AND irq_gate, ORed to irq out
// - Interrupt also routed to numbered core line
// - Irq clears on wrap or bit31-zero write
// - No counting while gated core clock stopped
// - extra_pair_flag read-only, set if next pair
// - context_scope root-writable, else reads zero
// - Scope selects root, intervention or guest events
// - Guest versus root event classification
// - irq_gate masks bit 31, resets zero
// - Reserved control bits read zero, write zero
// - Only mode-sensitive events use mode bits
// - Never count in debug or error level
// - Idle after reset until control written
// - Event 128 virtualization events per counter
// - Event 45 load-to-use stalls on counter 0
// - Event 63 counts each clock the custom input is high
// - Registers at coprocessor register 25, selects 0-3
`ifndef PEC_REGS_VH
`define PEC_REGS_VH
`define PEC_CP_REG 5'h19
`define PEC_SEL_CTL0 3'h0
`define PEC_SEL_CNT0 3'h1
`define PEC_SEL_CTL1 3'h2
`define PEC_SEL_CNT1 3'h3
`define PEC_B_PAIR 31
`define PEC_B_SCOPE_HI 24
`define PEC_B_SCOPE_LO 23
`define PEC_B_VIRT_HI 14
`define PEC_B_VIRT_LO 11
`define PEC_B_EVT_HI 10
`define PEC_B_EVT_LO 5
`define PEC_B_IRQ 4
`define PEC_B_APP 3
`define PEC_B_PRIV 1
`define PEC_B_EXC 0
`define PEC_B_TOP 31
`define PEC_SCOPE_ROOT 2'h0
`define PEC_SCOPE_RINT 2'h1
`define PEC_SCOPE_GUEST 2'h2
`define PEC_SCOPE_BOTH 2'h3
`define PEC_EV_CYCLES 6'h00
`define PEC_EV_CUSTOM 6'h3F
`define PEC_VIRT_BASE 4'h2
`define PEC_VIRT_LAST 3'h7
`define PEC_MODE0_LO 64'h00026700409BC01E
`define PEC_MODE0_HI 8'hBF
`define PEC_MODE1_LO 64'h00020408100B8002
`define PEC_MODE1_HI 8'hFF
`define PEC_VALID0_LO 64'h80026700409FC01F
`define PEC_VALID0_HI 8'hBF
`define PEC_VALID1_LO 64'h80020408120B8003
`define PEC_VALID1_HI 8'hFF
`endif

// file: pec_sync.v
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
module pec_sync #(
	parameter W = 2
) (
	input wire clk,
	input wire arst_n,
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
		end
		else
		begin
			meta_r <= d;
			sync_r <= meta_r;
		end
	end
	assign q = sync_r;
endmodule

// file: pec_evsel.v
// Event selection and mode/context filtering for one counter
`timescale 1ns/100ps
`include "pec_regs.vh"
module pec_evsel #(
	parameter [63:0] MODE_LO = 64'h0,
	parameter [7:0] MODE_HI = 8'h00,
	parameter [63:0] VALID_LO = 64'h0,
	parameter [7:0] VALID_HI = 8'h00
) (
	input wire [5:0] event_sel,
	input wire [3:0] virt_event_sel,
	input wire [1:0] context_scope,
	input wire count_in_app_level,
	input wire count_in_priv_level,
	input wire count_in_exc_level,
	input wire [63:0] ev_lo,
	input wire [7:0] ev_virt,
	input wire custom_ev,
	input wire user_mode,
	input wire exc_level,
	input wire error_level,
	input wire debug_active_flag,
	input wire guest_active_flag,
	output reg inc
);
	reg hit;
	reg valid;
	reg sens;
	reg mode_ok;
	reg ctx_ok;
	reg guest_ev;
	reg rint_ev;
	always @*
	begin
		hit = 1'b0;
		valid = 1'b0;
		sens = 1'b0;
		// Upper selector picks the virtualization page; other pages idle
		if (virt_event_sel == 4'h0)
		begin
			valid = VALID_LO[event_sel];
			sens = MODE_LO[event_sel];
			if (event_sel == `PEC_EV_CYCLES)
				hit = 1'b1;
			else if (event_sel == `PEC_EV_CUSTOM)
				hit = custom_ev;
			else
				hit = ev_lo[event_sel];
		end
		else if (virt_event_sel == `PEC_VIRT_BASE &&
			event_sel[5:3] == 3'h0)
		begin
			valid = VALID_HI[event_sel[2:0]];
			sens = MODE_HI[event_sel[2:0]];
			hit = ev_virt[event_sel[2:0]];
		end
		mode_ok = !sens ||
			(count_in_app_level && user_mode) ||
			(count_in_priv_level && !user_mode && !exc_level &&
			!error_level) ||
			(count_in_exc_level && exc_level && !error_level);
		guest_ev = guest_active_flag && !exc_level && !error_level &&
			!debug_active_flag;
		rint_ev = guest_active_flag && !guest_ev;
		case (context_scope)
		`PEC_SCOPE_ROOT: ctx_ok = !guest_active_flag;
		`PEC_SCOPE_RINT: ctx_ok = rint_ev;
		`PEC_SCOPE_GUEST: ctx_ok = guest_ev;
		`PEC_SCOPE_BOTH: ctx_ok = guest_ev || rint_ev;
		default: ctx_ok = 1'b0;
		endcase
		inc = hit && valid && mode_ok && ctx_ok &&
			!debug_active_flag && !error_level;
	end
endmodule

// file: pec_sva.sv
// Port assertions for the event counter unit
`timescale 1ns/100ps
module pec_sva #(
	parameter NUM_LINES = 8
) (
	input wire CLK_SYS,
	input wire ARST_N,
	input wire CORE_CLK_EN,
	input wire CP_WR,
	input wire CP_RD,
	input wire [4:0] CP_REGNUM,
	input wire [2:0] CP_SEL,
	input wire [31:0] CP_RDATA,
	input wire CP_RACK,
	input wire ROOT_MODE,
	input wire ERROR_LEVEL,
	input wire DEBUG_ACTIVE_FLAG,
	input wire [2:0] PERF_IRQ_LINE_NUM,
	input wire PERF_IRQ_OUT,
	input wire [NUM_LINES-1:0] CORE_IRQ_INPUTS
);
	wire rd25;
	wire ctl;
	wire run;
	wire [NUM_LINES-1:0] irq_w;
	assign rd25 = CP_RD && CP_REGNUM == 5'h19;
	assign ctl = rd25 && !CP_SEL[0] && !CP_SEL[2];
	// An interrupt edge needs a write or an edge that was allowed to count
	assign run = CP_WR || CORE_CLK_EN && !DEBUG_ACTIVE_FLAG && !ERROR_LEVEL;
	assign irq_w = {{(NUM_LINES-1){1'h0}}, PERF_IRQ_OUT};
	default clocking @(posedge CLK_SYS);
	endclocking
	default disable iff (!ARST_N);
	a_read_ack: assert property (rd25 |=> CP_RACK)
		else $error("read not acknowledged");
	a_rdata_hold: assert property (!rd25 |=> $stable(CP_RDATA))
		else $error("read data moved");
	a_ctl_zeros: assert property (
		ctl |=> !(CP_RDATA & 32'h7E7F8004))
		else $error("reserved control bits set");
	a_pair_flag: assert property (
		ctl |=> CP_RDATA[31] == !$past(CP_SEL[1]))
		else $error("pair flag wrong");
	a_scope_hidden: assert property (
		ctl && !ROOT_MODE |=> CP_RDATA[24:23] == 2'h0)
		else $error("scope visible outside root");
	a_irq_line: assert property (
		$stable(PERF_IRQ_LINE_NUM) |->
		CORE_IRQ_INPUTS == irq_w << PERF_IRQ_LINE_NUM)
		else $error("core line copy wrong");
	a_irq_rise: assert property ($rose(PERF_IRQ_OUT) |-> $past(run))
		else $error("interrupt rose while halted");
	a_irq_fall: assert property ($fell(PERF_IRQ_OUT) |-> $past(run))
		else $error("interrupt fell without cause");
	c_irq: cover property ($rose(PERF_IRQ_OUT));
	c_clear: cover property ($fell(PERF_IRQ_OUT));
	c_hidden: cover property (ctl && !ROOT_MODE);
endmodule
bind pec_top pec_sva #(.NUM_LINES(NUM_LINES)) u_sva (.CLK_SYS, .ARST_N,
	.CORE_CLK_EN, .CP_WR, .CP_RD, .CP_REGNUM, .CP_SEL, .CP_RDATA, .CP_RACK,
	.ROOT_MODE, .ERROR_LEVEL, .DEBUG_ACTIVE_FLAG, .PERF_IRQ_LINE_NUM,
	.PERF_IRQ_OUT, .CORE_IRQ_INPUTS);

// file: pec_evsrc.sv
// Pipeline event source model: one strobe per clock for a chosen event
`timescale 1ns/100ps
module pec_evsrc (
	input wire clk,
	input wire arst_n,
	input wire en,
	input wire [7:0] num,
	output reg [63:0] ev0,
	output reg [63:0] ev1,
	output reg [7:0] v0,
	output reg [7:0] v1
);
	// A held request looks like a pipeline retiring one event every clock
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ev0 <= 64'h0;
			ev1 <= 64'h0;
			v0 <= 8'h0;
			v1 <= 8'h0;
		end
		else
		begin
			ev0 <= (en && !num[7]) ? 64'h1 << num[5:0] : 64'h0;
			ev1 <= (en && !num[7]) ? 64'h1 << num[5:0] : 64'h0;
			v0 <= (en && num[7]) ? 8'h1 << num[2:0] : 8'h0;
			v1 <= (en && num[7]) ? 8'h1 << num[2:0] : 8'h0;
		end
	end
endmodule

// file: pec_tb_top.sv
// Self-checking bench for the two-counter event unit
`timescale 1ns/100ps
module pec_tb_top;
	reg CLK_SYS, ARST_N, CORE_CLK_EN, CP_WR, CP_RD, ROOT_MODE, USER_MODE;
	reg EXC_LEVEL, ERROR_LEVEL, DEBUG_ACTIVE_FLAG, GUEST_ACTIVE_FLAG;
	reg CUSTOM_EVENT_IN0, CUSTOM_EVENT_IN1;
	reg [4:0] CP_REGNUM;
	reg [2:0] CP_SEL, PERF_IRQ_LINE_NUM;
	reg [31:0] CP_WDATA, a, b;
	reg [35:0] t;
	reg [7:0] ev_num;
	wire [31:0] CP_RDATA;
	wire CP_RACK, PERF_IRQ_OUT;
	wire [7:0] CORE_IRQ_INPUTS, EV0_VIRT_IN, EV1_VIRT_IN;
	wire [63:0] EV0_IN, EV1_IN;
	integer n_errors, comparisons, i;
	// Entry: {user, exc, guest, counts} then the control word
	localparam [359:0] TT = {
		36'h9_000005A8,
		36'h9_00001008,
		36'hA_00000028,
		36'hB_01000028,
		36'h9_00000000,
		36'h5_00000021,
		36'h4_00000022,
		36'h1_00000022,
		36'h0_00000028,
		36'h9_00000028};
	// Per step {debug, error level, core clock}: sleep, error, debug
	localparam [8:0] HALT = 9'h158;
	pec_top uut (.CLK_SYS, .ARST_N, .CORE_CLK_EN, .CP_WR, .CP_RD, .CP_REGNUM,
		.CP_SEL, .CP_WDATA, .CP_RDATA, .CP_RACK, .ROOT_MODE, .USER_MODE,
		.EXC_LEVEL, .ERROR_LEVEL, .DEBUG_ACTIVE_FLAG, .GUEST_ACTIVE_FLAG,
		.EV0_IN, .EV0_VIRT_IN, .EV1_IN, .EV1_VIRT_IN, .CUSTOM_EVENT_IN0,
		.CUSTOM_EVENT_IN1, .PERF_IRQ_LINE_NUM, .PERF_IRQ_OUT,
		.CORE_IRQ_INPUTS);
	pec_evsrc src (.clk(CLK_SYS), .arst_n(ARST_N), .en(1'h1), .num(ev_num),
		.ev0(EV0_IN), .ev1(EV1_IN), .v0(EV0_VIRT_IN), .v1(EV1_VIRT_IN));
	initial
	begin
		CLK_SYS = 1'h0;
		forever #25 CLK_SYS = ~CLK_SYS;
	end
	task results;
	begin
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
	begin
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			n_errors = n_errors + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [2:0] s, input [31:0] d);
	begin
		@(posedge CLK_SYS);
		CP_WR <= 1'h1;
		CP_SEL <= s;
		CP_WDATA <= d;
		@(posedge CLK_SYS);
		CP_WR <= 1'h0;
	end
	endtask
	task rd(input [4:0] r, input [2:0] s, output [31:0] d);
		integer k;
		reg ack;
	begin
		@(posedge CLK_SYS);
		CP_RD <= 1'h1;
		CP_REGNUM <= r;
		CP_SEL <= s;
		@(posedge CLK_SYS);
		CP_RD <= 1'h0;
		CP_REGNUM <= 5'h19;
		ack = 1'h0;
		for (k = 0; k < 3 && ack !== 1'h1; k = k + 1)
		begin
			@(negedge CLK_SYS);
			ack = CP_RACK;
		end
		d = CP_RDATA;
		chk({31'h0, ack}, {31'h0, r == 5'h19});
		if (ack !== 1'h1 && r == 5'h19)
			results;
	end
	endtask
	// Two reads n clocks apart span n+2 counting edges
	task delta(input [2:0] s, input [31:0] n, input [31:0] exp);
	begin
		rd(5'h19, s, a);
		repeat (n) @(posedge CLK_SYS);
		rd(5'h19, s, b);
		chk(b - a, exp);
	end
	endtask
	task irq(input [31:0] exp);
	begin
		@(negedge CLK_SYS);
		chk({23'h0, CORE_IRQ_INPUTS, PERF_IRQ_OUT}, exp);
	end
	endtask
	initial
	begin
		n_errors = 0;
		comparisons = 0;
		{ARST_N, CP_WR, CP_RD, USER_MODE, EXC_LEVEL} = 5'h0;
		{ERROR_LEVEL, DEBUG_ACTIVE_FLAG, GUEST_ACTIVE_FLAG} = 3'h0;
		{CORE_CLK_EN, ROOT_MODE, CUSTOM_EVENT_IN0, CUSTOM_EVENT_IN1} = 4'hD;
		CP_REGNUM = 5'h19;
		CP_SEL = 3'h0;
		CP_WDATA = 32'h0;
		PERF_IRQ_LINE_NUM = 3'h5;
		ev_num = 8'h1;
		repeat (12) @(posedge CLK_SYS);
		ARST_N <= 1'h1;
		for (i = 0; i < 4; i = i + 1)
		begin
			rd(5'h19, i[2:0], a);
			chk(a, i ? 32'h0 : 32'h80000000);
		end
		rd(5'h19, 3'h5, a);
		chk(a, 32'h0);
		rd(5'h18, 3'h1, a);
		wr(3'h0, 32'h018007FB);
		rd(5'h19, 3'h0, a);
		chk(a, 32'h818007FB);
		wr(3'h2, 32'h810007FB);
		rd(5'h19, 3'h2, a);
		chk(a, 32'h010007FB);
		@(posedge CLK_SYS);
		ROOT_MODE <= 1'h0;
		rd(5'h19, 3'h0, a);
		chk(a, 32'h800007FB);
		@(posedge CLK_SYS);
		ROOT_MODE <= 1'h1;
		wr(3'h2, 32'h7E0);
		wr(3'h0, 32'h7E0);
		delta(3'h3, 10, 32'hC);
		delta(3'h1, 10, 32'h0);
		for (i = 0; i < 10; i = i + 1)
		begin
			t = TT[36*i +: 36];
			@(posedge CLK_SYS);
			{USER_MODE, EXC_LEVEL, GUEST_ACTIVE_FLAG} <= t[35:33];
			ev_num <= {t[12:11], t[10:5]};
			wr(3'h0, t[31:0]);
			delta(3'h1, 10, t[32] ? 32'hC : 32'h0);
		end
		wr(3'h0, 32'h0);
		for (i = 0; i < 3; i = i + 1)
		begin
			@(posedge CLK_SYS);
			{DEBUG_ACTIVE_FLAG, ERROR_LEVEL, CORE_CLK_EN} <= HALT[3 * i +: 3];
			delta(3'h1, 10, 32'h0);
		end
		@(posedge CLK_SYS);
		{DEBUG_ACTIVE_FLAG, ERROR_LEVEL, CORE_CLK_EN} <= 3'h1;
		GUEST_ACTIVE_FLAG <= 1'h0;
		wr(3'h0, 32'h10);
		wr(3'h1, 32'h7FFFFFFF);
		irq(32'h0);
		repeat (4) irq(32'h41);
		wr(3'h1, 32'h5);
		irq(32'h0);
		wr(3'h1, 32'hFFFFFFF8);
		// Seven counts from 0xFFFFFFF8 keep bit 31; the eighth wraps
		repeat (8) irq(32'h41);
		repeat (5) irq(32'h0);
		wr(3'h0, 32'h0);
		wr(3'h1, 32'h80000000);
		irq(32'h0);
		wr(3'h2, 32'h10);
		wr(3'h3, 32'hC0000000);
		irq(32'h41);
		wr(3'h3, 32'h0);
		irq(32'h0);
		wr(3'h1, 32'h100);
		rd(5'h19, 3'h1, a);
		chk(a, 32'h101);
		results;
	end
endmodule
